// ---- core/sar_readout.sv ----
/*
  Digital side of a 16-bit successive approximation converter: conversion
  sequencing, busy flag, gain compression, serial readout and chain forwarding.
  Assumes convert_start, shift_clk, read_enable_or_chain_input, chain_select and
  gain_compression_select come from outside the core clock domain, and that the
  analog core supplies a signed sample on sample_code.
*/
// Function
// [R1] Chain low: shared pin enables output
// [R2] Chain high: shared pin is serial input
// [R3] Drive output only while enable low
// [R4] Gain compression scales to 10..90 percent
// [R5] Convert edge wakes and starts conversion
// [R6] Busy high for whole conversion
// [R7] One bit per shift edge, MSB first
// [R8] Chain mode forwards upstream data out
// [R9] Chain input sampled on shift rising
// [R10] Result is two's complement
// [R11] Host limits shift clock rate
// [R12] Host idles shift clock after convert
// [R13] Conversion end loads 16-bit result
// [R14] Low power between conversions
// [R15] Host waits for busy fall
// [R16] Sixteen edges per converter read
`timescale 1ns/100ps
`include "sar_defs.svh"
module sar_readout #(
  parameter int CONV_CYCLES = `SAR_CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Host control pins.
  input  wire logic              convert_start,
  input  wire logic              shift_clk,
  input  wire logic              read_enable_or_chain_input,
  input  wire logic              chain_select,
  input  wire logic              gain_compression_select,
  // Analog core sample.
  input  wire sar_pkg::sar_word_t sample_code,
  // Status and serial output.
  output logic                   busy,
  output logic                   power_down,
  output logic                   serial_out,
  output logic                   serial_out_oe_n
);
  import sar_pkg::*;

  // ==========================================================================
  // Parameter check: the counter is sixteen bits and busy needs two cycles.
  // ==========================================================================
  if (CONV_CYCLES < `SAR_CONV_MIN || CONV_CYCLES > `SAR_CONV_MAX) begin : g_bad_conv
    $error("CONV_CYCLES out of range");
  end

  // ==========================================================================
  // Input synchronisers.
  // ==========================================================================
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       cnv_prev;
  logic       sck_prev;
  wire  [4:0] raw_in = {gain_compression_select, chain_select,
                        read_enable_or_chain_input, shift_clk, convert_start};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire cnv_s    = sync_b[0];
  wire sck_s    = sync_b[1];
  wire shared_s = sync_b[2];
  wire chain_s  = sync_b[3];
  wire gc_ref_s = sync_b[4];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnv_prev <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      cnv_prev <= cnv_s;
      sck_prev <= sck_s;
    end
  end

  wire cnv_rise = cnv_s & ~cnv_prev;
  wire sck_rise = sck_s & ~sck_prev;

  // ==========================================================================
  // Conversion sequencer.
  // ==========================================================================
  sar_state_e  state;
  logic [15:0] conv_cnt;
  wire         conv_done = (state == SAR_CONVERT) &&
                           (conv_cnt == 16'(CONV_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SAR_SLEEP;
    end else begin
      case (state)
        SAR_SLEEP:   if (cnv_rise) state <= SAR_CONVERT; // [R5]
        SAR_CONVERT: if (conv_done) state <= SAR_READY;
        SAR_READY:   if (cnv_rise) state <= SAR_CONVERT; // [R5]
        default:     state <= SAR_SLEEP;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt <= 16'h0000;
    end else if (state != SAR_CONVERT) begin
      conv_cnt <= 16'h0000;
    end else begin
      conv_cnt <= conv_cnt + 16'h0001;
    end
  end

  // Busy spans the conversion; power down holds otherwise.
  assign busy       = (state == SAR_CONVERT); // [R6]
  assign power_down = (state != SAR_CONVERT); // [R14]

  // ==========================================================================
  // Gain compression: code scaled by 0.8 keeps span inside 10..90 percent.
  // ==========================================================================
  logic signed [31:0] scaled;
  always_comb begin
    scaled = $signed(sample_code) * $signed({1'b0, `SAR_GC_MUL});
  end
  wire sar_word_t comp_code = sar_word_t'(scaled >>> `SAR_GC_SHIFT);
  // Tied to reference means no compression.
  wire sar_word_t result_code = gc_ref_s ? sample_code : comp_code; // [R4] [R10]

  // ==========================================================================
  // Shift register: loaded at conversion end, shifted per shift edge unless enable is high in normal mode.
  // ==========================================================================
  sar_word_t shreg;
  logic      out_bit;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= `SAR_ZERO_WORD;
    end else if (conv_done) begin
      shreg <= result_code; // [R13]
    end else if (sck_rise && (chain_s || !shared_s)) begin
      // Chain mode shifts in upstream data; normal mode shifts in zero.
      shreg <= {shreg[`SAR_WORD_BITS-2:0], chain_s & shared_s}; // [R7] [R8] [R9] [R16]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_bit <= 1'b0;
    end else begin
      out_bit <= shreg[`SAR_WORD_BITS-1];
    end
  end

  assign serial_out = out_bit;
  // Normal mode: enable low drives; chain mode always drives.
  assign serial_out_oe_n = chain_s ? 1'b0 : shared_s; // [R1] [R2] [R3]

  // ==========================================================================
  // Assertion helpers: conversion length and normal shifts since the load.
  // ==========================================================================
  logic [15:0] busy_len;
  logic [4:0]  shift_cnt;
  wire         shift_now = sck_rise && !conv_done && (chain_s || !shared_s);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_len <= 16'h0000;
    end else if (!busy) begin
      busy_len <= 16'h0000;
    end else begin
      busy_len <= busy_len + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_cnt <= 5'h00;
    end else if (conv_done || chain_s) begin
      shift_cnt <= 5'h00;
    end else if (shift_now && (shift_cnt != 5'h1f)) begin
      shift_cnt <= shift_cnt + 5'h01;
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  a_busy_on_start: assert property ( // [R6]
    @(posedge core_clk) disable iff (!reset_n)
    (cnv_rise && !busy) |=> busy
  ) else $error("busy did not rise");

  a_busy_length: assert property ( // [R6]
    @(posedge core_clk) disable iff (!reset_n)
    $rose(busy) |-> busy [*2]
  ) else $error("busy too short");

  a_busy_ends: assert property ( // [R6]
    @(posedge core_clk) disable iff (!reset_n)
    conv_done |=> !busy
  ) else $error("busy stayed high");

  a_sleep_hold: assert property ( // [R14]
    @(posedge core_clk) disable iff (!reset_n)
    (power_down && !cnv_rise) |=> power_down
  ) else $error("woke early");

  a_load_word: assert property ( // [R13]
    @(posedge core_clk) disable iff (!reset_n)
    conv_done |=> shreg == $past(result_code)
  ) else $error("no load");

  a_msb_first: assert property ( // [R7]
    @(posedge core_clk) disable iff (!reset_n)
    (sck_rise && !conv_done && (chain_s || !shared_s)) |=>
    shreg[`SAR_WORD_BITS-1] == $past(shreg[`SAR_WORD_BITS-2])
  ) else $error("bad shift");

  a_chain_in: assert property ( // [R9]
    @(posedge core_clk) disable iff (!reset_n)
    (sck_rise && !conv_done && chain_s) |=> shreg[0] == $past(shared_s)
  ) else $error("chain bit lost");

  a_normal_oe: assert property ( // [R3]
    @(posedge core_clk) disable iff (!reset_n)
    !chain_s |-> serial_out_oe_n == shared_s
  ) else $error("bad enable");

  a_chain_oe: assert property ( // [R2]
    @(posedge core_clk) disable iff (!reset_n)
    chain_s |-> !serial_out_oe_n
  ) else $error("chain not driving");

  a_no_compress: assert property ( // [R4]
    @(posedge core_clk) disable iff (!reset_n)
    (conv_done && gc_ref_s) |=> shreg == $past(sample_code)
  ) else $error("unexpected scaling");

  a_compress_load: assert property ( // [R4]
    @(posedge core_clk) disable iff (!reset_n)
    (conv_done && !gc_ref_s) |=> shreg == $past(comp_code)
  ) else $error("compression not applied");

  a_sign_kept: assert property ( // [R10]
    @(posedge core_clk) disable iff (!reset_n)
    conv_done |=> shreg[`SAR_WORD_BITS-1] == $past(sample_code[`SAR_WORD_BITS-1])
  ) else $error("sign lost");

  a_rise_ignored: assert property ( // [R5]
    @(posedge core_clk) disable iff (!reset_n)
    (busy && cnv_rise && !conv_done) |=> busy && (conv_cnt == $past(conv_cnt) + 16'h0001)
  ) else $error("conversion restarted");

  a_busy_count: assert property ( // [R6]
    @(posedge core_clk) disable iff (!reset_n)
    $fell(busy) |-> busy_len == 16'(CONV_CYCLES)
  ) else $error("busy length wrong");

  a_idle_count: assert property ( // [R6]
    @(posedge core_clk) disable iff (!reset_n)
    !busy |=> conv_cnt == 16'h0000
  ) else $error("counter runs while idle");

  a_power_mirror: assert property ( // [R14]
    @(posedge core_clk) disable iff (!reset_n)
    power_down != busy
  ) else $error("power state wrong");

  a_sleep_done: assert property ( // [R14]
    @(posedge core_clk) disable iff (!reset_n)
    conv_done |=> power_down
  ) else $error("awake after conversion");

  a_shreg_hold: assert property ( // [R7]
    @(posedge core_clk) disable iff (!reset_n)
    (!conv_done && !shift_now) |=> $stable(shreg)
  ) else $error("shift without edge");

  a_refuse_shift: assert property ( // [R1] [R3]
    @(posedge core_clk) disable iff (!reset_n)
    (sck_rise && !chain_s && shared_s && !conv_done) |=> $stable(shreg)
  ) else $error("shift while disabled");

  a_chain_shift: assert property ( // [R8]
    @(posedge core_clk) disable iff (!reset_n)
    (shift_now && chain_s) |=> shreg[`SAR_WORD_BITS-1:1] == $past(shreg[`SAR_WORD_BITS-2:0])
  ) else $error("chain word not forwarded");

  a_out_follows: assert property ( // [R7] [R8]
    @(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> serial_out == $past(shreg[`SAR_WORD_BITS-1])
  ) else $error("output bit wrong");

  a_word_out: assert property ( // [R16]
    @(posedge core_clk) disable iff (!reset_n)
    (shift_cnt == 5'(`SAR_WORD_BITS) && !chain_s) |-> shreg == `SAR_ZERO_WORD
  ) else $error("word not fully shifted");
endmodule

// ---- include/sar_defs.svh ----
/*
  Constants for the converter readout block: word width, conversion timing,
  gain compression scaling.
  Assumes a 100 MHz core clock.
*/
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_CLK_PERIOD_PS  10000
`define SAR_CONV_TIME_PS   300000
`define SAR_CONV_CYCLES    ((`SAR_CONV_TIME_PS) / (`SAR_CLK_PERIOD_PS))
`define SAR_CONV_MIN       2
`define SAR_CONV_MAX       65535
`define SAR_WORD_BITS      16
`define SAR_GC_MUL         16'h3333
`define SAR_GC_SHIFT       14
`define SAR_GC_ADD_SHIFT   0
`define SAR_ZERO_WORD      16'h0000
`endif

// ---- include/sar_pkg.sv ----
/*
  Types for the converter readout block.
  Assumes sar_defs.svh is on the include path.
*/
`include "sar_defs.svh"
package sar_pkg;
  typedef logic [`SAR_WORD_BITS-1:0] sar_word_t;
  typedef enum logic [1:0] {
    SAR_SLEEP,
    SAR_CONVERT,
    SAR_READY
  } sar_state_e;
endpackage

// ---- sim/sar_host.sv ----
/*
  Host and upstream converter model: framed shift clock and chain data.
  Assumes the readout block's pins are wired to it by name.
*/
`timescale 1ns/100ps
module sar_host (
  // Pins toward the converter.
  output logic      convert_start,
  output logic      shift_clk,
  output logic      chain_data,
  // Pin from the converter.
  input  wire logic serial_out
);
  // ==========
  // Frame driver.
  initial begin
    convert_start = 1'b0;
    shift_clk     = 1'b0;
    chain_data    = 1'b1;
  end
  task automatic frame(input int n, input logic [15:0] up, output logic [31:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      chain_data = up[15 - (i % 16)];
      #40 got = {got[30:0], serial_out};
      shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
    end
    chain_data = ~chain_data;
  endtask
endmodule

// ---- sim/sar_adc_serial_readout_test.sv ----
/*
  Self-checking bench for the converter readout block.
  Assumes sar_host drives the convert, shift clock and chain pins.
*/
`timescale 1ns/100ps
module sar_adc_serial_readout_test;
  import sar_pkg::*;
  localparam int CONV = 8;
  logic      core_clk, reset_n, chain_select, gcs, enable_n;
  wire       convert_start, shift_clk, chain_data, busy, power_down, serial_out, serial_out_oe_n;
  sar_word_t sample_code;
  logic [31:0] got;
  int        n_errors, num_checks, k;
  // Rows: chain and compression select, sample, expected result.
  logic [1:0] r_mode [4] = '{2'b01, 2'b00, 2'b00, 2'b11};
  sar_word_t  r_in [4]   = '{16'h7FFF, 16'h7FFF, 16'h8000, 16'h00F0};
  sar_word_t  r_exp [4]  = '{16'h7FFF, 16'h6665, 16'h999A, 16'h00F0};
  sar_word_t  up         = 16'hA5C3;
  sar_readout #(.CONV_CYCLES(CONV)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .convert_start(convert_start), .shift_clk(shift_clk),
    .read_enable_or_chain_input(chain_select ? chain_data : enable_n),
    .chain_select(chain_select), .gain_compression_select(gcs),
    .sample_code(sample_code), .busy(busy), .power_down(power_down),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  sar_host host (.convert_start(convert_start), .shift_clk(shift_clk),
    .chain_data(chain_data), .serial_out(serial_out_oe_n ? ~serial_out : serial_out));
  // ==========
  // Checking and closing.
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Conversion with a second convert rise while busy.
  task automatic convert;
    int c;
    @(negedge core_clk) host.convert_start = 1'b1;
    c = 0;
    while (busy !== 1'b1 && c < 20) begin
      @(negedge core_clk);
      c++;
    end
    check(c < 20, "busy never rose");
    if (c >= 20) stop_test();
    check(power_down === 1'b0, "asleep while converting");
    c = 0;
    while (busy === 1'b1 && c < 100) begin
      @(negedge core_clk);
      c++;
      if (c == 1 || c == 5) host.convert_start = 1'b0;
      if (c == 3) host.convert_start = 1'b1;
    end
    check(c == CONV, "busy length");
    repeat (6) @(negedge core_clk);
    check(busy === 1'b0 && power_down === 1'b1, "late convert not refused");
  endtask
  // ==========
  // Clock and main sequence.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    chain_select = 1'b0;
    gcs = 1'b1;
    enable_n = 1'b0;
    sample_code = 16'h0000;
    repeat (10) @(negedge core_clk);
    check(busy === 1'b0 && power_down === 1'b1 && serial_out === 1'b0, "reset values");
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    for (k = 0; k < 4; k++) begin
      {chain_select, gcs} = r_mode[k];
      sample_code = r_in[k];
      convert();
      check(serial_out_oe_n === 1'b0, "output not driven");
      host.frame(chain_select ? 32 : 16, up, got);
      check((chain_select ? got[31:16] : got[15:0]) === r_exp[k], "result");
      if (chain_select) check(got[15:0] === up, "chain data");
    end
    chain_select = 1'b0;
    enable_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check(serial_out_oe_n === 1'b1, "output not released");
    enable_n = 1'b0;
    repeat (4) @(negedge core_clk);
    check(serial_out_oe_n === 1'b0, "output not enabled");
    // Reset in mid conversion, then a refused and an enabled read.
    @(negedge core_clk) host.convert_start = 1'b1;
    repeat (5) @(negedge core_clk);
    check(busy === 1'b1, "busy missing");
    reset_n = 1'b0;
    @(negedge core_clk);
    check(busy === 1'b0 && power_down === 1'b1, "reset ignored");
    host.convert_start = 1'b0;
    reset_n = 1'b1;
    convert();
    enable_n = 1'b1;
    repeat (4) @(negedge core_clk);
    host.frame(16, up, got);
    check(got[15:0] === 16'hFFFF, "released bus driven");
    enable_n = 1'b0;
    repeat (4) @(negedge core_clk);
    host.frame(16, up, got);
    check(got[15:0] === 16'h00F0, "shift while disabled");
    stop_test();
  end
endmodule
